// [hw/dia_pkg.sv]
package dia_pkg;
   localparam int DIA_DATA_W = 32;
   localparam int DIA_UNIT_W = 16;
   localparam int DIA_DIV_UNITS = 4;
   localparam int DIA_CTR_FIRST = 200;
   localparam int DIA_CTR_LAST = 255;
   localparam logic [31:0] DIA_MOST_NEG = 32'h8000_0000;
   localparam logic [31:0] DIA_ZERO_WORD = 32'h0000_0000;
   localparam logic [31:0] DIA_ONE_WORD = 32'h0000_0001;
   localparam logic [5:0] DIA_ITER_LAST = 6'h1F;
   localparam logic [5:0] DIA_ROOT_ITER_LAST = 6'h0F;
   localparam logic [5:0] DIA_ITER_RESET = 6'h00;

   typedef enum logic [2:0]
   {
      DIA_OP_DIV = 3'h0,
      DIA_OP_SQRT = 3'h1,
      DIA_OP_INC = 3'h2,
      DIA_OP_DEC = 3'h3,
      DIA_OP_ABS = 3'h4,
      DIA_OP_NEG = 3'h5
   } dia_op_t;

   typedef struct packed
   {
      dia_op_t op;
      logic dest_is_counter;
      logic [7:0] counter_index;
      logic [31:0] src_a;
      logic [31:0] src_b;
   } dia_req_t;

   typedef struct packed
   {
      logic [15:0] unit0;
      logic [15:0] unit1;
      logic [15:0] unit2;
      logic [15:0] unit3;
      logic [2:0] unit_count;
      logic zero_flag;
      logic borrow_flag;
      logic flags_valid;
      logic div_zero_err;
      logic operand_err;
   } dia_resp_t;
endpackage : dia_pkg

// [hw/dia_divsqrt.sv]
`timescale 1ns/1ns
// shared iterative core: unsigned restoring divide or bitwise square root
module dia_divsqrt
   import dia_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic is_sqrt_in,
   input wire logic [31:0] num_in,
   input wire logic [31:0] den_in,
   output logic done_out,
   output logic [31:0] quot_out,
   output logic [31:0] rem_out
);
   logic busy_reg;
   logic sqrt_reg;
   logic [5:0] iter_reg;
   logic [31:0] num_reg;
   logic [31:0] den_reg;
   logic [31:0] quot_reg;
   logic [33:0] rem_reg;
   logic [33:0] trial;
   logic [33:0] rem_shift;
   logic trial_ok;

   always_comb
   begin
      if (sqrt_reg)
      begin
         // two source bits per step, trial = 4*root + 1
         rem_shift = {rem_reg[31:0], num_reg[31:30]};
         trial = {quot_reg, 2'b01};
      end
      else
      begin
         rem_shift = {rem_reg[32:0], num_reg[31]};
         trial = {2'b00, den_reg};
      end
      trial_ok = (rem_shift >= trial);
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         busy_reg <= 1'b0;
         done_out <= 1'b0;
         sqrt_reg <= 1'b0;
         iter_reg <= DIA_ITER_RESET;
         num_reg <= DIA_ZERO_WORD;
         den_reg <= DIA_ZERO_WORD;
         quot_reg <= DIA_ZERO_WORD;
         rem_reg <= 34'h0_0000_0000;
      end
      else
      begin
         done_out <= 1'b0;
         if (start_in && !busy_reg)
         begin
            busy_reg <= 1'b1;
            sqrt_reg <= is_sqrt_in;
            iter_reg <= is_sqrt_in ? DIA_ROOT_ITER_LAST : DIA_ITER_LAST;
            num_reg <= num_in;
            den_reg <= den_in;
            quot_reg <= DIA_ZERO_WORD;
            rem_reg <= 34'h0_0000_0000;
         end
         else if (busy_reg)
         begin
            rem_reg <= trial_ok ? rem_shift - trial : rem_shift;
            quot_reg <= {quot_reg[30:0], trial_ok};
            num_reg <= sqrt_reg ? {num_reg[29:0], 2'b00}
                                : {num_reg[30:0], 1'b0};
            if (iter_reg == DIA_ITER_RESET)
            begin
               busy_reg <= 1'b0;
               done_out <= 1'b1;
            end
            else
               iter_reg <= iter_reg - 6'h01;
         end
      end
   end

   assign quot_out = quot_reg;
   assign rem_out = rem_reg[31:0];
endmodule : dia_divsqrt

// [hw/dia_unit.sv]
`timescale 1ns/1ns
// Overview of operation
// - enabled divide: first operand over second
// - divide writes quotient pair then remainder pair
// - zero divisor: error, destination untouched
// - enabled square root of 32-bit source
// - zero root sets zero flag
// - discarded root fraction sets borrow flag
// - negative root source: operand error, skip
// - increment wraps around 32-bit signed range
// - increment counter target only counters 200 to 255
// - decrement wraps around 32-bit signed range
// - magnitude of source written to destination
// - magnitude of most negative: operand error
// - negation writes two's-complement negative
// - negation of most negative: operand error
module dia_unit
   import dia_pkg::*;
(
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   input wire logic REQ_VALID_IN,
   input wire logic POWER_FLOW_IN,
   input wire dia_req_t REQ_IN,
   output logic REQ_READY_OUT,
   output logic RESP_VALID_OUT,
   output logic RESP_WRITE_OUT,
   output dia_resp_t RESP_OUT
);
   typedef enum logic [2:0]
   {
      DIA_ST_IDLE = 3'b001,
      DIA_ST_ITER = 3'b010,
      DIA_ST_DONE = 3'b100
   } dia_state_t;

   dia_state_t state_reg;
   dia_state_t state_next;
   dia_op_t op_reg;
   logic sign_q_reg;
   logic sign_r_reg;
   logic [31:0] sqrt_src_reg;
   logic core_start;
   logic core_done;
   logic [31:0] core_quot;
   logic [31:0] core_rem;
   logic [31:0] quot_signed;
   logic [31:0] rem_signed;
   logic take;
   logic is_iter_op;
   logic [31:0] abs_a;
   logic [31:0] abs_b;
   logic [31:0] simple_val;
   logic simple_err;
   logic simple_div0;
   logic [31:0] sq_check;
   logic simple_fire;
   logic iter_fire;
   logic resp_fire;
   logic [31:0] first_word;
   logic [31:0] second_word;
   logic [3:0][15:0] unit_next;
   logic [3:0][15:0] unit_reg;
   logic [2:0] count_next;
   logic [2:0] count_reg;
   logic zero_next;
   logic zero_reg;
   logic borrow_next;
   logic borrow_reg;
   logic flags_next;
   logic flags_reg;
   logic div0_next;
   logic div0_reg;
   logic opnd_next;
   logic opnd_reg;

   function automatic logic [31:0] magnitude(input logic [31:0] v);
      magnitude = v[31] ? (DIA_ZERO_WORD - v) : v;
   endfunction : magnitude

   function automatic logic counter_ok(input logic [7:0] idx);
      counter_ok = (32'(idx) >= DIA_CTR_FIRST)
                   && (32'(idx) <= DIA_CTR_LAST);
   endfunction : counter_ok

   assign REQ_READY_OUT = (state_reg == DIA_ST_IDLE);
   assign take = REQ_VALID_IN && REQ_READY_OUT && POWER_FLOW_IN;
   assign abs_a = magnitude(REQ_IN.src_a);
   assign abs_b = magnitude(REQ_IN.src_b);
   assign is_iter_op = ((REQ_IN.op == DIA_OP_DIV)
                        && (REQ_IN.src_b != DIA_ZERO_WORD))
                       || ((REQ_IN.op == DIA_OP_SQRT) && !REQ_IN.src_a[31]);
   assign core_start = take && is_iter_op;

   always_comb
   begin
      simple_val = DIA_ZERO_WORD;
      simple_err = 1'b0;
      simple_div0 = 1'b0;
      unique case (REQ_IN.op)
         DIA_OP_DIV:
            simple_div0 = (REQ_IN.src_b == DIA_ZERO_WORD);
         DIA_OP_SQRT:
            simple_err = REQ_IN.src_a[31];
         DIA_OP_INC:
         begin
            // plain 32-bit add wraps max to min by itself
            simple_val = REQ_IN.src_a + DIA_ONE_WORD;
            simple_err = REQ_IN.dest_is_counter
                         && !counter_ok(REQ_IN.counter_index);
         end
         DIA_OP_DEC:
            simple_val = REQ_IN.src_a - DIA_ONE_WORD;
         DIA_OP_ABS:
         begin
            simple_val = abs_a;
            simple_err = (REQ_IN.src_a == DIA_MOST_NEG);
         end
         DIA_OP_NEG:
         begin
            simple_val = DIA_ZERO_WORD - REQ_IN.src_a;
            simple_err = (REQ_IN.src_a == DIA_MOST_NEG);
         end
         default:
            simple_err = 1'b1;
      endcase
   end

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         DIA_ST_IDLE:
            if (core_start)
               state_next = DIA_ST_ITER;
         DIA_ST_ITER:
            if (core_done)
               state_next = DIA_ST_DONE;
         DIA_ST_DONE:
            state_next = DIA_ST_IDLE;
         default:
            state_next = DIA_ST_IDLE;
      endcase
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_N_IN)
         state_reg <= DIA_ST_IDLE;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_N_IN)
      begin
         op_reg <= DIA_OP_DIV;
         sign_q_reg <= 1'b0;
         sign_r_reg <= 1'b0;
         sqrt_src_reg <= DIA_ZERO_WORD;
      end
      else if (core_start)
      begin
         op_reg <= REQ_IN.op;
         sign_q_reg <= REQ_IN.src_a[31] ^ REQ_IN.src_b[31];
         sign_r_reg <= REQ_IN.src_a[31];
         sqrt_src_reg <= REQ_IN.src_a;
      end
   end

   dia_divsqrt u_core
   (
      .clk_in(MCLK_IN),
      .rst_n_in(RST_N_IN),
      .start_in(core_start),
      .is_sqrt_in(REQ_IN.op == DIA_OP_SQRT),
      .num_in(REQ_IN.op == DIA_OP_SQRT ? REQ_IN.src_a : abs_a),
      .den_in(abs_b),
      .done_out(core_done),
      .quot_out(core_quot),
      .rem_out(core_rem)
   );

   // magnitudes divided unsigned, signs restored afterwards
   assign quot_signed = sign_q_reg ? (DIA_ZERO_WORD - core_quot)
                                   : core_quot;
   assign rem_signed = sign_r_reg ? (DIA_ZERO_WORD - core_rem)
                                  : core_rem;
   // root squared differs from source when a fraction was dropped
   assign sq_check = {16'h0000, core_quot[15:0]}
                     * {16'h0000, core_quot[15:0]};

   // simple ops answer only from idle, the core only while iterating
   assign simple_fire = take && !is_iter_op;
   assign iter_fire = (state_reg == DIA_ST_ITER) && core_done;
   assign resp_fire = simple_fire || iter_fire;

   always_comb
   begin
      first_word = simple_val;
      second_word = DIA_ZERO_WORD;
      count_next = 3'h2;
      flags_next = 1'b0;
      zero_next = 1'b0;
      borrow_next = 1'b0;
      div0_next = simple_div0;
      opnd_next = simple_err;
      if (iter_fire)
      begin
         div0_next = 1'b0;
         opnd_next = 1'b0;
         if (op_reg == DIA_OP_SQRT)
         begin
            first_word = core_quot;
            flags_next = 1'b1;
            zero_next = (core_quot == DIA_ZERO_WORD);
            borrow_next = (sq_check != sqrt_src_reg);
         end
         else
         begin
            first_word = quot_signed;
            second_word = rem_signed;
            count_next = 3'(DIA_DIV_UNITS);
         end
      end
   end

   // low half of each word sits in the lower-numbered unit
   assign unit_next = {second_word, first_word};

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_N_IN)
      begin
         RESP_VALID_OUT <= 1'b0;
         RESP_WRITE_OUT <= 1'b0;
      end
      else
      begin
         RESP_VALID_OUT <= resp_fire;
         // errors leave the destination alone: no write strobe
         RESP_WRITE_OUT <= iter_fire || (simple_fire && !simple_err
                           && !simple_div0);
      end
   end

   // units hold until the next answer, so the sequencer may read late
   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_N_IN)
         unit_reg <= '0;
      else if (resp_fire)
         unit_reg <= unit_next;
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_N_IN)
         count_reg <= 3'h0;
      else if (resp_fire)
         count_reg <= count_next;
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_N_IN)
      begin
         flags_reg <= 1'b0;
         zero_reg <= 1'b0;
         borrow_reg <= 1'b0;
      end
      else if (resp_fire)
      begin
         flags_reg <= flags_next;
         zero_reg <= zero_next;
         borrow_reg <= borrow_next;
      end
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_N_IN)
      begin
         div0_reg <= 1'b0;
         opnd_reg <= 1'b0;
      end
      else if (resp_fire)
      begin
         div0_reg <= div0_next;
         opnd_reg <= opnd_next;
      end
   end

   assign RESP_OUT = '{unit0: unit_reg[0],
                       unit1: unit_reg[1],
                       unit2: unit_reg[2],
                       unit3: unit_reg[3],
                       unit_count: count_reg,
                       zero_flag: zero_reg,
                       borrow_flag: borrow_reg,
                       flags_valid: flags_reg,
                       div_zero_err: div0_reg,
                       operand_err: opnd_reg};
endmodule : dia_unit

// [verification/dia_unit_checker.sv]
`timescale 1ns/1ns
module dia_unit_checker
   import dia_pkg::*;
(
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   input wire logic REQ_VALID_IN,
   input wire logic POWER_FLOW_IN,
   input wire dia_req_t REQ_IN,
   input wire logic REQ_READY_OUT,
   input wire logic RESP_VALID_OUT,
   input wire logic RESP_WRITE_OUT,
   input wire dia_resp_t RESP_OUT
);
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);
   logic tk;
   logic ok;
   logic er;
   dia_op_t op;
   logic [31:0] a;
   logic [31:0] w0;
   assign tk = REQ_VALID_IN && REQ_READY_OUT && POWER_FLOW_IN;
   assign ok = RESP_VALID_OUT && RESP_WRITE_OUT;
   assign er = RESP_VALID_OUT && !RESP_WRITE_OUT;
   assign op = REQ_IN.op;
   assign a = REQ_IN.src_a;
   assign w0 = {RESP_OUT.unit1, RESP_OUT.unit0};
   inc_wrap_a: assert property (
      tk && op == DIA_OP_INC && !REQ_IN.dest_is_counter
      |=> ok && w0 == $past(a) + 32'h1) else $error("bad increment");
   dec_wrap_a: assert property (
      tk && op == DIA_OP_DEC |=> ok && w0 == $past(a) - 32'h1)
      else $error("bad decrement");
   neg_value_a: assert property (
      tk && op == DIA_OP_NEG && a != DIA_MOST_NEG
      |=> ok && w0 == DIA_ZERO_WORD - $past(a)) else $error("bad negate");
   most_neg_a: assert property (
      tk && op inside {DIA_OP_ABS, DIA_OP_NEG} && a == DIA_MOST_NEG
      |=> er && RESP_OUT.operand_err) else $error("no operand error");
   div_zero_a: assert property (
      tk && op == DIA_OP_DIV && REQ_IN.src_b == DIA_ZERO_WORD
      |=> er && RESP_OUT.div_zero_err) else $error("no divide error");
   sqrt_neg_a: assert property (
      tk && op == DIA_OP_SQRT && a[31] |=> er && RESP_OUT.operand_err)
      else $error("negative root ran");
   ctr_range_a: assert property (
      tk && op == DIA_OP_INC && REQ_IN.dest_is_counter
      && REQ_IN.counter_index < DIA_CTR_FIRST
      |=> er && RESP_OUT.operand_err) else $error("counter not refused");
   div_units_a: assert property (
      tk && op == DIA_OP_DIV && REQ_IN.src_b != DIA_ZERO_WORD
      |-> ##34 ok && RESP_OUT.unit_count == 3'h4) else $error("bad divide");
   sqrt_flag_a: assert property (
      tk && op == DIA_OP_SQRT && !a[31] |-> ##18 ok && RESP_OUT.flags_valid
      && RESP_OUT.zero_flag == ($past(a, 18) == DIA_ZERO_WORD))
      else $error("bad root");
   div_seen_c: cover property (tk && op == DIA_OP_DIV);
   sqrt_seen_c: cover property (tk && op == DIA_OP_SQRT);
   err_seen_c: cover property (er && RESP_OUT.operand_err);
endmodule : dia_unit_checker

bind dia_unit dia_unit_checker chk (.MCLK_IN, .RST_N_IN, .REQ_VALID_IN,
   .POWER_FLOW_IN, .REQ_IN, .REQ_READY_OUT, .RESP_VALID_OUT,
   .RESP_WRITE_OUT, .RESP_OUT);

// [verification/dia_seq_model.sv]
`timescale 1ns/1ns
module dia_seq_model
   import dia_pkg::*;
(
   input wire logic clk_in,
   input wire logic ready_in,
   output logic valid_out,
   output dia_req_t req_out
);
   logic rdy;
   initial
   begin
      valid_out = 1'b0;
      req_out = '0;
   end
   // ready sampled mid-cycle, it only moves on clock edges
   task automatic issue(input dia_req_t r);
      valid_out <= 1'b1;
      req_out <= r;
      do
      begin
         @(negedge clk_in);
         rdy = ready_in;
         @(posedge clk_in);
      end
      while (!rdy);
      valid_out <= 1'b0;
      // released lines show junk, so stale data cannot pass
      req_out <= ~r;
   endtask : issue
endmodule : dia_seq_model

// [verification/double_int_arith_unit_bench.sv]
`timescale 1ns/1ns
`define CHK(g, e) \
   num_checks++; \
   if ((g) !== (e)) \
   begin \
      fail_count++; \
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e); \
   end
module double_int_arith_unit_bench
   import dia_pkg::*;
;
   typedef struct packed
   {
      dia_op_t op;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] q;
      logic [31:0] r;
      logic [1:0] f;
      logic [1:0] e;
   } dia_row_t;
   logic clk;
   logic rst_n;
   logic pf;
   logic valid;
   logic rdy;
   logic v_o;
   logic w_o;
   logic got_w;
   logic seen;
   dia_req_t req;
   dia_req_t req_w;
   dia_resp_t rsp;
   int fail_count;
   int num_checks;
   dia_row_t rows [13] = '{
      '{DIA_OP_DIV, 32'h14438, 32'h7D0, 32'h29, 32'h3E8, 2'h0, 2'h0},
      '{DIA_OP_DIV, 32'hFFFFFFF9, 32'h2, 32'hFFFFFFFD, 32'hFFFFFFFF, 2'h0,
        2'h0},
      '{DIA_OP_DIV, 32'h5, 32'h0, 32'h0, 32'h0, 2'h0, 2'h2},
      '{DIA_OP_SQRT, 32'h14438, 32'h0, 32'h120, 32'h0, 2'h1, 2'h0},
      '{DIA_OP_SQRT, 32'h0, 32'h0, 32'h0, 32'h0, 2'h2, 2'h0},
      '{DIA_OP_SQRT, 32'h10, 32'h0, 32'h4, 32'h0, 2'h0, 2'h0},
      '{DIA_OP_SQRT, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 2'h0, 2'h1},
      '{DIA_OP_INC, 32'h7FFFFFFF, 32'h0, 32'h80000000, 32'h0, 2'h0, 2'h0},
      '{DIA_OP_DEC, 32'h80000000, 32'h0, 32'h7FFFFFFF, 32'h0, 2'h0, 2'h0},
      '{DIA_OP_ABS, 32'hFFFE7960, 32'h0, 32'h186A0, 32'h0, 2'h0, 2'h0},
      '{DIA_OP_ABS, 32'h80000000, 32'h0, 32'h0, 32'h0, 2'h0, 2'h1},
      '{DIA_OP_NEG, 32'h186A0, 32'h0, 32'hFFFE7960, 32'h0, 2'h0, 2'h0},
      '{DIA_OP_NEG, 32'h80000000, 32'h0, 32'h0, 32'h0, 2'h0, 2'h1}};
   dia_unit DUT
   (
      .MCLK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(valid),
      .POWER_FLOW_IN(pf), .REQ_IN(req_w), .REQ_READY_OUT(rdy),
      .RESP_VALID_OUT(v_o), .RESP_WRITE_OUT(w_o), .RESP_OUT(rsp)
   );
   dia_seq_model seq
   (
      .clk_in(clk), .ready_in(rdy), .valid_out(valid), .req_out(req_w)
   );
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   // bounded wait: longest answer is the 34-cycle divide
   task automatic go(input dia_req_t r, output logic s);
      s = 1'b0;
      seq.issue(r);
      for (int i = 0; i < 40 && !s; i++)
      begin
         @(negedge clk);
         s = v_o;
         got_w = w_o;
      end
      @(posedge clk);
   endtask : go
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      fail_count++;
      summarize();
   end
   initial
   begin
      rst_n = 1'b0;
      pf = 1'b1;
      req = '0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      `CHK({rdy, v_o, rsp}, {2'h2, 72'h0})
      @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i])
      begin
         req = '{rows[i].op, 1'b0, 8'h00, rows[i].a, rows[i].b};
         go(req, seen);
         `CHK(seen, 1'b1)
         `CHK(got_w, rows[i].e == 2'h0)
         `CHK({rsp.div_zero_err, rsp.operand_err}, rows[i].e)
         if (rows[i].e == 2'h0)
         begin
            `CHK({rsp.unit1, rsp.unit0}, rows[i].q)
            if (rows[i].op == DIA_OP_DIV)
            begin
               `CHK({rsp.unit3, rsp.unit2}, rows[i].r)
            end
            if (rows[i].op == DIA_OP_SQRT)
            begin
               `CHK({rsp.zero_flag, rsp.borrow_flag}, rows[i].f)
            end
         end
      end
      req = '{DIA_OP_INC, 1'b1, 8'hC7, 32'h5, 32'h0};
      go(req, seen);
      `CHK({got_w, rsp.operand_err}, 2'h1)
      req.counter_index = 8'hC8;
      go(req, seen);
      `CHK({got_w, rsp.unit0}, 17'h10006)
      // reset in mid-divide: the job is dropped, no stray answer
      req = '{DIA_OP_DIV, 1'b0, 8'h00, 32'h14438, 32'h7D0};
      seq.issue(req);
      repeat (4) @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK({rdy, v_o, w_o, rsp}, {3'h4, 72'h0})
      @(posedge clk);
      rst_n <= 1'b1;
      req = '{DIA_OP_DEC, 1'b0, 8'h00, 32'h0, 32'h0};
      go(req, seen);
      `CHK({seen, got_w, rsp.unit1, rsp.unit0}, 34'h3_FFFF_FFFF)
      // enable low: request must be ignored outright
      pf <= 1'b0;
      go(req, seen);
      `CHK(seen, 1'b0)
      summarize();
   end
endmodule : double_int_arith_unit_bench
